// ==== logic/dmme_alu.sv ====
// unsigned multiplier and two's-complement negate with flags
`timescale 1ns/1ps
module dmme_alu
    import dmme_pkg::*;
#(
    parameter int DW = 8
) (
    // multiply operands and product
    input wire logic [DW-1:0] mul_a,
    input wire logic [DW-1:0] mul_b,
    output logic [2*DW-1:0] product,
    // negate operand, result and flags
    input wire logic [DW-1:0] neg_in,
    output logic [DW-1:0] neg_res,
    output logic [FLAG_W-1:0] neg_flags
);
    logic [DW:0] diff;
    logic [NIB_W:0] nib_diff;

    // product cannot overflow the double width
    assign product = {{DW{1'b0}}, mul_a} * {{DW{1'b0}}, mul_b};

    // negate done as zero minus operand so carries follow subtraction
    assign diff = {(DW+1){1'b0}} - {1'b0, neg_in};
    assign nib_diff = {(NIB_W+1){1'b0}} - {1'b0, neg_in[NIB_W-1:0]};
    assign neg_res = diff[DW-1:0];

    // carry means no borrow, so only a zero operand sets it
    always_comb begin
        neg_flags = '0;
        neg_flags[FLG_C] = ~diff[DW];
        neg_flags[FLG_DC] = ~nib_diff[NIB_W];
        neg_flags[FLG_Z] = (neg_res == '0);
        neg_flags[FLG_OV] = (neg_in == {1'b1, {(DW-1){1'b0}}});
        neg_flags[FLG_N] = neg_res[DW-1];
    end
endmodule : dmme_alu

// ==== logic/dmme_core.sv ====
// instruction execution core for moves, literal loads, multiply and negate
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - move decoded as source word then destination word
// - move copies byte across full absolute space
// - accumulator location usable as move source/destination
// - move: read first cycle, write last phase
// - moves, loads and store keep flags
// - bank literal load in one cycle
// - accumulator literal load in one cycle
// - accumulator stored to file in one cycle
// - access bit picks access bank or bank
// - literal multiply into product pair, accumulator kept
// - file multiply into product pair, operands kept
// - multiplies single cycle, flags untouched
// - negate file in place, five flags updated
module dmme_core
    import dmme_pkg::*;
#(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // clock, reset, freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    dmme_state_type state_r;
    dmme_op_type kind;
    logic [1:0] phase_r;
    logic [15:0] instr_r;
    logic [DW-1:0] acc_r, bank_r, prod_lo_r, prod_hi_r;
    logic [FLAG_W-1:0] flags_r, neg_flags, nflags_r;
    logic [DW-1:0] operand_r, result_r, neg_res, mul_b;
    logic [2*DW-1:0] product, prod_r;
    logic [AW-1:0] file_addr, rd_addr, dw_addr, mem_addr, sw_addr_r;
    logic second_r, badseq_r, unknown_r, needs_read, exec, ph_read, ph_proc, ph_write;
    logic dw_en, mem_we, mem_re, sw_rd_pend_r, sw_wr_pend_r, sw_cap_r, sw_rd_go, sw_wr_go;
    logic [DW-1:0] mem_wdata, mem_rdata, sw_wdata_r, sw_data_r;
    logic dp_rd_r, dp_wr_r, rd_ok_r, ap_go;
    logic [7:0] dp_off_r;
    logic [31:0] hrdata_r;
    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // banked or access-bank address of a single-word file operand
    function automatic logic [AW-1:0] bank_addr(input logic [15:0] iw, input logic [DW-1:0] bk);
        logic [3:0] hi;
        hi = bk[3:0];
        if (!iw[ACCESS_BIT]) begin
            hi = (iw[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK;
        end
        return {hi, iw[7:0]};
    endfunction : bank_addr
    // core registers that live in the data space
    function automatic logic is_core_reg(input logic [AW-1:0] a);
        return (a == DADDR_ACC) || (a == DADDR_BANK) || (a == DADDR_PROD_LO)
            || (a == DADDR_PROD_HI) || (a == DADDR_FLAGS);
    endfunction : is_core_reg
    // bus write strobe for one register offset
    function automatic logic bus_wr(input logic [7:0] off);
        return dp_wr_r && (dp_off_r == off);
    endfunction : bus_wr

    // ------------------------------------------------------------
    // decode and address forming
    // ------------------------------------------------------------
    assign kind = dmme_decode(instr_r, second_r);
    assign exec = (state_r == s_exec);
    assign ph_read = exec && (phase_r == PH_READ);
    assign ph_proc = exec && (phase_r == PH_PROC);
    assign ph_write = exec && (phase_r == PH_WRITE);
    assign file_addr = bank_addr(instr_r, bank_r);
    // move addresses are absolute, bank register plays no part
    assign rd_addr = (kind == op_move_src) ? instr_r[11:0] : file_addr;
    assign dw_addr = (kind == op_move_dst) ? instr_r[11:0] : file_addr;
    // second move word neither reads nor dummy reads
    assign needs_read = (kind == op_move_src) || (kind == op_mul_file)
        || (kind == op_neg_file);
    assign mul_b = (kind == op_mul_lit) ? instr_r[7:0] : operand_r;
    assign dw_en = ph_write && ((kind == op_move_dst) || (kind == op_store_acc)
        || (kind == op_neg_file));

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    dmme_alu #(.DW(DW)) u_alu (
        .mul_a(acc_r),
        .mul_b(mul_b),
        .product(product),
        .neg_in(operand_r),
        .neg_res(neg_res),
        .neg_flags(neg_flags)
    );
    // core owns the port while executing, software otherwise
    assign sw_wr_go = !exec && sw_wr_pend_r;
    assign sw_rd_go = !exec && !sw_wr_pend_r && sw_rd_pend_r;
    assign mem_re = exec ? (phase_r == PH_DECODE) && needs_read : sw_rd_go;
    assign mem_we = exec ? dw_en && !is_core_reg(dw_addr) : sw_wr_go;
    assign mem_addr = exec ? ((phase_r == PH_DECODE) ? rd_addr : dw_addr) : sw_addr_r;
    assign mem_wdata = exec ? result_r : sw_wdata_r;
    dmme_dmem #(.AW(AW), .DW(DW)) u_dmem (
        .clk(hclk),
        .ce(ce),
        .we(mem_we),
        .re(mem_re),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // one instruction cycle is four phases; a move parks between words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= s_idle;
            phase_r <= PH_DECODE;
            second_r <= 1'b0;
            instr_r <= '0;
        end else if (ce) begin
            case (state_r)
                s_idle, s_wait2: begin
                    if (bus_wr(REG_INSTR)) begin
                        instr_r <= hwdata[15:0];
                        second_r <= (state_r == s_wait2);
                        phase_r <= PH_DECODE;
                        state_r <= s_exec;
                    end
                end
                s_exec: begin
                    phase_r <= phase_r + 2'h1;
                    if (phase_r == PH_WRITE) begin
                        state_r <= (kind == op_move_src) ? s_wait2 : s_idle;
                    end
                end
                default: begin
                    state_r <= s_idle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // datapath phases
    // ------------------------------------------------------------
    // operand fetch in phase two, core registers bypass memory
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operand_r <= '0;
        end else if (ce && ph_read && needs_read) begin
            case (rd_addr)
                DADDR_ACC: operand_r <= acc_r;
                DADDR_BANK: operand_r <= bank_r;
                DADDR_PROD_LO: operand_r <= prod_lo_r;
                DADDR_PROD_HI: operand_r <= prod_hi_r;
                DADDR_FLAGS: operand_r <= DW'(flags_r);
                default: operand_r <= mem_rdata;
            endcase
        end
    end

    // processing in phase three, results wait for phase four
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= '0;
            prod_r <= '0;
            nflags_r <= '0;
        end else if (ce && ph_proc) begin
            prod_r <= product;
            nflags_r <= neg_flags;
            case (kind)
                op_load_bank, op_load_acc: result_r <= instr_r[7:0];
                op_store_acc: result_r <= acc_r;
                op_neg_file: result_r <= neg_res;
                default: result_r <= operand_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // architectural registers, written in phase four
    // ------------------------------------------------------------
    // accumulator: literal load, move, store or negate into its location, or software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= '0;
        end else if (ce) begin
            if (ph_write && (kind == op_load_acc)) begin
                acc_r <= result_r;
            end else if (dw_en && (dw_addr == DADDR_ACC)) begin
                acc_r <= result_r;
            end else if (!exec && bus_wr(REG_ACC)) begin
                acc_r <= hwdata[DW-1:0];
            end
        end
    end

    // bank select register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_r <= '0;
        end else if (ce) begin
            if (ph_write && (kind == op_load_bank)) begin
                bank_r <= result_r;
            end else if (dw_en && (dw_addr == DADDR_BANK)) begin
                bank_r <= result_r;
            end else if (!exec && bus_wr(REG_BANK)) begin
                bank_r <= hwdata[DW-1:0];
            end
        end
    end

    // product pair, high byte in the upper register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prod_lo_r <= '0;
            prod_hi_r <= '0;
        end else if (ce) begin
            if (ph_write && ((kind == op_mul_lit) || (kind == op_mul_file))) begin
                prod_lo_r <= prod_r[DW-1:0];
                prod_hi_r <= prod_r[2*DW-1:DW];
            end else if (dw_en && (dw_addr == DADDR_PROD_LO)) begin
                prod_lo_r <= result_r;
            end else if (dw_en && (dw_addr == DADDR_PROD_HI)) begin
                prod_hi_r <= result_r;
            end
        end
    end

    // flags: only negate computes them; its flags win over a write of itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= '0;
        end else if (ce) begin
            if (ph_write && (kind == op_neg_file)) begin
                flags_r <= nflags_r;
            end else if (dw_en && (dw_addr == DADDR_FLAGS)) begin
                flags_r <= result_r[FLAG_W-1:0];
            end else if (!exec && bus_wr(REG_FLAGS)) begin
                flags_r <= hwdata[FLAG_W-1:0];
            end
        end
    end

    // sticky faults, a new fault wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            badseq_r <= 1'b0;
            unknown_r <= 1'b0;
        end else if (ce) begin
            if (ph_write && (kind == op_bad_dst)) begin
                badseq_r <= 1'b1;
            end else if (bus_wr(REG_STATUS) && hwdata[ST_BADSEQ]) begin
                badseq_r <= 1'b0;
            end
            if (ph_write && (kind == op_unknown)) begin
                unknown_r <= 1'b1;
            end else if (bus_wr(REG_STATUS) && hwdata[ST_UNKNOWN]) begin
                unknown_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // software window into the data space
    // ------------------------------------------------------------
    // requests wait while the core owns the memory port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_addr_r <= '0;
            sw_wdata_r <= '0;
            sw_rd_pend_r <= 1'b0;
            sw_wr_pend_r <= 1'b0;
            sw_cap_r <= 1'b0;
            sw_data_r <= '0;
        end else if (ce) begin
            sw_cap_r <= sw_rd_go;
            if (sw_cap_r) begin
                sw_data_r <= mem_rdata;
            end else if (sw_wr_go) begin
                sw_data_r <= sw_wdata_r;
            end
            if (bus_wr(REG_MEM_ADDR)) begin
                sw_addr_r <= hwdata[AW-1:0];
                sw_rd_pend_r <= 1'b1;
            end else if (sw_rd_go) begin
                sw_rd_pend_r <= 1'b0;
            end
            if (bus_wr(REG_MEM_DATA)) begin
                sw_wdata_r <= hwdata[DW-1:0];
                sw_wr_pend_r <= 1'b1;
            end else if (sw_wr_go) begin
                sw_wr_pend_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    // reads take one wait state so a write just before is visible
    assign ap_go = hsel && htrans[HTRANS_ACTIVE] && hready;
    assign hreadyout = ce && !(dp_rd_r && !rd_ok_r);
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_r;
    // data-phase tracking, frozen with everything else while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_rd_r <= 1'b0;
            dp_wr_r <= 1'b0;
            rd_ok_r <= 1'b0;
            dp_off_r <= '0;
        end else if (ce) begin
            rd_ok_r <= hready ? 1'b0 : dp_rd_r;
            if (hready) begin
                dp_rd_r <= ap_go && !hwrite;
                dp_wr_r <= ap_go && hwrite;
                if (ap_go) begin
                    dp_off_r <= haddr[7:0];
                end
            end
        end
    end

    // read mux, unmapped offsets read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (ce && dp_rd_r && !rd_ok_r) begin
            case (dp_off_r)
                REG_INSTR: hrdata_r <= 32'(instr_r);
                REG_ACC: hrdata_r <= 32'(acc_r);
                REG_BANK: hrdata_r <= 32'(bank_r);
                REG_PROD_LO: hrdata_r <= 32'(prod_lo_r);
                REG_PROD_HI: hrdata_r <= 32'(prod_hi_r);
                REG_FLAGS: hrdata_r <= 32'(flags_r);
                REG_STATUS: begin
                    hrdata_r <= '0;
                    hrdata_r[ST_BUSY] <= exec;
                    hrdata_r[ST_WAIT2] <= (state_r == s_wait2);
                    hrdata_r[ST_BADSEQ] <= badseq_r;
                    hrdata_r[ST_UNKNOWN] <= unknown_r;
                end
                REG_MEM_ADDR: hrdata_r <= 32'(sw_addr_r);
                REG_MEM_DATA: hrdata_r <= 32'(sw_data_r);
                default: hrdata_r <= '0;
            endcase
        end
    end
endmodule : dmme_core

// ==== logic/dmme_dmem.sv ====
// single-port data space memory with registered read data
`timescale 1ns/1ps
module dmme_dmem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // clock and freeze
    input wire logic clk,
    input wire logic ce,
    // access port
    input wire logic we,
    input wire logic re,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array, contents are undefined until written
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            if (re) begin
                rdata <= mem[addr];
            end
        end
    end
endmodule : dmme_dmem

// ==== logic/dmme_pkg.sv ====
// shared constants, types and decode for the move/multiply execution block
package dmme_pkg;
    // ------------------------------------------------------------
    // opcode patterns
    // ------------------------------------------------------------
    localparam logic [3:0] OPC_MOVE_SRC = 4'hC;
    localparam logic [3:0] OPC_MOVE_DST = 4'hF;
    localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
    localparam logic [7:0] OPC_LOAD_ACC = 8'h0E;
    localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;
    localparam logic [6:0] OPC_STORE_ACC = 7'h37;
    localparam logic [6:0] OPC_NEG_FILE = 7'h36;
    localparam int ACCESS_BIT = 8;
    // ------------------------------------------------------------
    // data-space map of core registers and access bank split
    // ------------------------------------------------------------
    localparam logic [11:0] DADDR_ACC = 12'hF00;
    localparam logic [11:0] DADDR_BANK = 12'hF01;
    localparam logic [11:0] DADDR_PROD_LO = 12'hF02;
    localparam logic [11:0] DADDR_PROD_HI = 12'hF03;
    localparam logic [11:0] DADDR_FLAGS = 12'hF04;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    // ------------------------------------------------------------
    // flag and status bit positions
    // ------------------------------------------------------------
    localparam int FLAG_W = 5;
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;
    localparam int NIB_W = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_WAIT2 = 1;
    localparam int ST_BADSEQ = 2;
    localparam int ST_UNKNOWN = 3;
    // ------------------------------------------------------------
    // bus register offsets, phases, bus codes
    // ------------------------------------------------------------
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_BANK = 8'h08;
    localparam logic [7:0] REG_PROD_LO = 8'h0C;
    localparam logic [7:0] REG_PROD_HI = 8'h10;
    localparam logic [7:0] REG_FLAGS = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_MEM_ADDR = 8'h1C;
    localparam logic [7:0] REG_MEM_DATA = 8'h20;
    localparam logic [1:0] PH_DECODE = 2'h0;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_PROC = 2'h2;
    localparam logic [1:0] PH_WRITE = 2'h3;
    localparam int HTRANS_ACTIVE = 1;
    localparam logic HRESP_OKAY = 1'b0;
    // ------------------------------------------------------------
    // types and decode
    // ------------------------------------------------------------
    typedef enum {s_idle, s_exec, s_wait2} dmme_state_type;
    typedef enum {op_move_src, op_move_dst, op_bad_dst, op_load_bank, op_load_acc,
        op_store_acc, op_mul_lit, op_mul_file, op_neg_file, op_unknown} dmme_op_type;

    // second tells whether the word completes a two-word move
    function automatic dmme_op_type dmme_decode(input logic [15:0] iw, input logic second);
        dmme_op_type k;
        k = op_unknown;
        if (second) begin
            k = (iw[15:12] == OPC_MOVE_DST) ? op_move_dst : op_bad_dst;
        end else if (iw[15:12] == OPC_MOVE_SRC) begin
            k = op_move_src;
        end else if (iw[15:8] == OPC_LOAD_BANK) begin
            k = op_load_bank;
        end else if (iw[15:8] == OPC_LOAD_ACC) begin
            k = op_load_acc;
        end else if (iw[15:8] == OPC_MUL_LIT) begin
            k = op_mul_lit;
        end else if (iw[15:9] == OPC_MUL_FILE) begin
            k = op_mul_file;
        end else if (iw[15:9] == OPC_STORE_ACC) begin
            k = op_store_acc;
        end else if (iw[15:9] == OPC_NEG_FILE) begin
            k = op_neg_file;
        end
        return k;
    endfunction : dmme_decode
endpackage : dmme_pkg

// ==== tb/dmme_core_monitor.sv ====
// bus-side assertion checker for the execution core
`timescale 1ns/1ps
module dmme_core_monitor
    import dmme_pkg::*;
(
    // clock, reset, freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave view
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    // taken address phases; a frozen core takes nothing
    logic tk;
    logic rtk;
    assign tk = hsel & htrans[1] & hready & ce;
    assign rtk = tk & !hwrite;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    a_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    a_frozen_stall: assert property (!ce |-> !hreadyout)
        else $error("ready while frozen");
    a_read_wait: assert property (rtk |=> !hreadyout)
        else $error("read without wait state");
    a_read_done: assert property (rtk ##1 ce ##1 ce |-> hreadyout)
        else $error("read wait too long");
    a_write_zero: assert property (tk && hwrite ##1 ce |-> hreadyout)
        else $error("write stalled");
    a_wait_cause: assert property (ce && $past(ce) && !hreadyout |-> $past(rtk))
        else $error("stall without read");
    a_rdata_hold: assert property (!$stable(hrdata) |-> $past(rtk, 2))
        else $error("read data moved");
    a_unmapped_zero: assert property (rtk && haddr[7:0] > 8'h20 |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_acc_narrow: assert property (rtk && haddr[7:0] == REG_ACC |-> ##2 hrdata[31:8] == 24'h0)
        else $error("accumulator upper bits set");
endmodule : dmme_core_monitor

bind dmme_core dmme_core_monitor u_mon (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .hrdata);

// ==== tb/dmme_core_tb.sv ====
// self-checking bench for the execution core
`timescale 1ns/1ps
module dmme_core_tb
    import dmme_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rq;
    int err_total = 0;
    int checks_done = 0;
    always #12.5 hclk = ~hclk;
    // single slave: its ready is the bus ready
    dmme_core DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata);
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // sample at the falling edge so ready and data are settled
    task automatic wt();
        logic r;
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rq = hrdata;
            n++;
            @(posedge hclk);
        end while (r !== 1'b1 && n < 64);
        if (r !== 1'b1) begin
            chk("hready", 32'h1, {31'h0, r});
        end
    endtask : wt
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wt();
        htrans <= 2'h0;
        hwdata <= d;
        wt();
    endtask : xfer
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rq);
    endtask : rchk
    // poll busy rather than trusting a fixed latency
    task automatic ex(input logic [15:0] iw);
        int n;
        n = 0;
        xfer(1'b1, REG_INSTR, {16'h0, iw});
        do begin
            xfer(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rq[ST_BUSY] !== 1'b0 && n < 20);
        if (rq[ST_BUSY] !== 1'b0) begin
            chk("busy", 32'h0, {31'h0, rq[ST_BUSY]});
        end
    endtask : ex
    task automatic mem(input logic w, input logic [11:0] a, input logic [7:0] v);
        xfer(1'b1, REG_MEM_ADDR, {20'h0, a});
        if (w) begin
            xfer(1'b1, REG_MEM_DATA, {24'h0, v});
        end
        repeat (4) @(posedge hclk);
        xfer(1'b0, REG_MEM_DATA, 32'h0);
    endtask : mem
    // {n, ov, z, dc, c, result} of zero minus the operand
    function automatic logic [12:0] neg_exp(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h0 - v;
        return {r[7], v == 8'h80, r == 8'h0, v[3:0] == 4'h0, v == 8'h0, r};
    endfunction : neg_exp
    initial begin
        #1000000;
        err_total++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] a, k, b, f, v;
        logic [11:0] d;
        logic [4:0] fl;
        logic [12:0] e;
        void'($urandom(38));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ce <= 1'b0;
        @(negedge hclk);
        chk("ready_frozen", 32'h0, {31'h0, hreadyout});
        @(posedge hclk);
        ce <= 1'b1;
        rchk("unmapped", 8'h40, 32'h0);
        ex(16'hC000);
        ex(16'h1234);
        chk("bad_second", 32'h4, rq & 32'h4);
        ex(16'h0000);
        chk("unknown_op", 32'h8, rq & 32'h8);
        xfer(1'b1, REG_STATUS, 32'hC);
        rchk("status_clear", REG_STATUS, 32'h0);
        // first two rounds take the negate corners 0x80 and 0x00
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom);
            k = 8'($urandom);
            b = 8'($urandom % 15);
            f = 8'($urandom % 128);
            d = 12'($urandom % 12'hF00);
            fl = 5'($urandom);
            v = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : 8'($urandom);
            xfer(1'b1, REG_FLAGS, {27'h0, fl});
            ex({8'h0E, a});
            rchk("acc", REG_ACC, {24'h0, a});
            ex({8'h01, b});
            rchk("bank", REG_BANK, {24'h0, b});
            ex({8'h0D, k});
            rchk("prod_lit", REG_PROD_HI, {24'h0, 8'((16'(a) * k) >> 8)});
            rchk("acc_kept", REG_ACC, {24'h0, a});
            ex({8'h6E, f});
            mem(1'b0, {4'h0, f}, 8'h0);
            chk("store_access", {24'h0, a}, rq);
            ex({8'h6F, f});
            mem(1'b0, {b[3:0], f}, 8'h0);
            chk("store_banked", {24'h0, a}, rq);
            ex({8'h03, f});
            rchk("prod_file", REG_PROD_LO, {24'h0, 8'(16'(a) * a)});
            ex({4'hC, DADDR_ACC});
            ex({4'hF, d});
            mem(1'b0, d, 8'h0);
            chk("move_from_acc", {24'h0, a}, rq);
            ex({8'h0E, k});
            ex({4'hC, d});
            ex({4'hF, DADDR_ACC});
            rchk("move_to_acc", REG_ACC, {24'h0, a});
            rchk("flags_kept", REG_FLAGS, {27'h0, fl});
            mem(1'b1, {4'h0, f}, v);
            ex({8'h6C, f});
            e = neg_exp(v);
            mem(1'b0, {4'h0, f}, 8'h0);
            chk("negate", {24'h0, e[7:0]}, rq);
            rchk("neg_flags", REG_FLAGS, {27'h0, e[12:8]});
        end
        report_and_stop();
    end
endmodule : dmme_core_tb
